// ### hdl/ctp_pkg.sv
// Constants, encodings and register map of the cascaded timer block.
// Assumes an 8-bit register port with a 4-bit word address.
package ctp_pkg;

    // ------------------------------------------------------------------
    // Register word addresses
    // ------------------------------------------------------------------
    localparam logic [3:0] CTP_ADDR_CTRL     = 4'h0;
    localparam logic [3:0] CTP_ADDR_LOW_CMP  = 4'h1;
    localparam logic [3:0] CTP_ADDR_HIGH_CMP = 4'h2;
    localparam logic [3:0] CTP_ADDR_ALT_CMP  = 4'h3;
    localparam logic [3:0] CTP_ADDR_CAR_CTRL = 4'h4;
    localparam logic [3:0] CTP_ADDR_LOW_CNT  = 4'h5;
    localparam logic [3:0] CTP_ADDR_HIGH_CNT = 4'h6;
    localparam logic [3:0] CTP_ADDR_STATUS   = 4'h7;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTP_CTRL_LOW_RUN  = 0;
    localparam int CTP_CTRL_HIGH_RUN = 1;
    localparam int CTP_CTRL_OUT_EN   = 2;
    localparam int CTP_CTRL_SEL_LSB  = 3;
    localparam int CTP_CTRL_SEL_MSB  = 5;
    localparam int CTP_CTRL_MODE_LSB = 6;
    localparam int CTP_CTRL_MODE_MSB = 7;

    // ------------------------------------------------------------------
    // Carrier output control fields
    // ------------------------------------------------------------------
    localparam int CTP_CAR_GATE_FLAG  = 0;
    localparam int CTP_CAR_GATE_BUF   = 1;
    localparam int CTP_CAR_REMOTE_SEL = 2;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int CTP_STAT_WAVE    = 0;
    localparam int CTP_STAT_ALT_SEL = 1;
    localparam int CTP_STAT_OUT     = 2;

    // ------------------------------------------------------------------
    // Modes, reset values and count clock masks
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CTP_MODE_INTERVAL16 = 2'h0,
        CTP_MODE_SQUARE16   = 2'h1,
        CTP_MODE_CARRIER    = 2'h2,
        CTP_MODE_PWM        = 2'h3
    } ctp_mode_e;

    localparam logic [7:0] CTP_BYTE_ZERO = 8'h00;
    localparam logic [7:0] CTP_BYTE_FULL = 8'hff;
    localparam logic [7:0] CTP_BYTE_ONE  = 8'h01;

    localparam logic [2:0] CTP_SEL_DIV1   = 3'h0;
    localparam logic [2:0] CTP_SEL_DIV4A  = 3'h1;
    localparam logic [2:0] CTP_SEL_DIV2   = 3'h2;
    localparam logic [2:0] CTP_SEL_DIV4B  = 3'h3;
    localparam logic [2:0] CTP_SEL_DIV8   = 3'h4;
    localparam logic [2:0] CTP_SEL_DIV16  = 3'h5;

    localparam logic [3:0] CTP_MASK_DIV1  = 4'h0;
    localparam logic [3:0] CTP_MASK_DIV2  = 4'h1;
    localparam logic [3:0] CTP_MASK_DIV4  = 4'h3;
    localparam logic [3:0] CTP_MASK_DIV8  = 4'h7;
    localparam logic [3:0] CTP_MASK_DIV16 = 4'hf;

endpackage : ctp_pkg

// ### hdl/ctp_prescaler.sv
// Count clock prescaler: one-cycle tick at the selected division of clk_i.
// Assumes run_i comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ctp_prescaler
    import ctp_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       run_i,
    input  wire logic [2:0] sel_i,
    output logic            tick_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } ctp_pre_s;

    ctp_pre_s   st_q;
    ctp_pre_s   st_d;
    logic [3:0] mask;
    logic       legal;

    // ------------------------------------------------------------------
    // Division select
    // ------------------------------------------------------------------
    always_comb begin
        legal = 1'b1;
        case (sel_i)
            CTP_SEL_DIV1:  mask = CTP_MASK_DIV1;
            CTP_SEL_DIV4A: mask = CTP_MASK_DIV4;
            CTP_SEL_DIV2:  mask = CTP_MASK_DIV2;
            CTP_SEL_DIV4B: mask = CTP_MASK_DIV4;
            CTP_SEL_DIV8:  mask = CTP_MASK_DIV8;
            CTP_SEL_DIV16: mask = CTP_MASK_DIV16;
            default: begin
                mask  = CTP_MASK_DIV16;
                legal = 1'b0;
            end
        endcase
    end

    always_comb begin
        st_d = st_q;
        if (!run_i) begin
            st_d.cnt  = '0;
            st_d.tick = 1'b0;
        end else begin
            st_d.cnt  = st_q.cnt + 4'h1;
            st_d.tick = legal && ((st_q.cnt & mask) == mask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_o = st_q.tick;

endmodule : ctp_prescaler
`default_nettype wire

// ### hdl/ctp_timer.sv
// Cascaded 8+8 bit timer with 16-bit interval, 16-bit square wave,
// carrier generator and PWM modes, behind a byte-wide register port.
// Assumes one 50 MHz clock and synchronous register strobes.
`timescale 1ns/1ps
`default_nettype none
module ctp_timer
    import ctp_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    output logic            timer_out_pin_o,
    output logic            timer_out_oe_o,
    output logic            low_match_irq_o,
    output logic            high_match_irq_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             low_run;
        logic             high_run;
        logic             out_en;
        logic [2:0]       clk_sel;
        ctp_mode_e        mode;
        logic [CNT_W-1:0] low_cmp;
        logic [CNT_W-1:0] high_cmp;
        logic [CNT_W-1:0] alt_cmp;
        logic             remote_sel;
        logic             gate_buf;
        logic             gate_flag;
        logic [CNT_W-1:0] low_cnt;
        logic [CNT_W-1:0] high_cnt;
        logic             alt_sel;
        logic             wave;
        logic             low_irq;
        logic             high_irq;
        logic             pin;
        logic             oe;
        logic [7:0]       rdata;
    } ctp_state_s;

    ctp_state_s       st_q;
    ctp_state_s       st_d;
    logic             tick;
    logic             is16;
    logic             full_match;
    logic             low_match;
    logic [CNT_W-1:0] act_cmp;
    logic [7:0]       ctrl_rd;
    logic [7:0]       car_rd;
    logic [7:0]       stat_rd;

    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_FULL = '1;

    // ------------------------------------------------------------------
    // Count clock
    // ------------------------------------------------------------------
    ctp_prescaler u_pre (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .run_i   (st_q.low_run),
        .sel_i   (st_q.clk_sel),
        .tick_o  (tick)
    );

    // ------------------------------------------------------------------
    // Compare logic
    // ------------------------------------------------------------------
    always_comb begin
        is16       = (st_q.mode == CTP_MODE_INTERVAL16) || (st_q.mode == CTP_MODE_SQUARE16);
        act_cmp    = st_q.alt_sel ? st_q.alt_cmp : st_q.low_cmp;
        low_match  = (st_q.low_cnt == act_cmp);
        full_match = (st_q.low_cnt == st_q.low_cmp) && (st_q.high_cnt == st_q.high_cmp);
    end

    // ------------------------------------------------------------------
    // Register read images
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_rd                                       = CTP_BYTE_ZERO;
        ctrl_rd[CTP_CTRL_LOW_RUN]                     = st_q.low_run;
        ctrl_rd[CTP_CTRL_HIGH_RUN]                    = st_q.high_run;
        ctrl_rd[CTP_CTRL_OUT_EN]                      = st_q.out_en;
        ctrl_rd[CTP_CTRL_SEL_MSB:CTP_CTRL_SEL_LSB]    = st_q.clk_sel;
        ctrl_rd[CTP_CTRL_MODE_MSB:CTP_CTRL_MODE_LSB]  = st_q.mode;
        car_rd                                        = CTP_BYTE_ZERO;
        car_rd[CTP_CAR_GATE_FLAG]                     = st_q.gate_flag;
        car_rd[CTP_CAR_GATE_BUF]                      = st_q.gate_buf;
        car_rd[CTP_CAR_REMOTE_SEL]                    = st_q.remote_sel;
        stat_rd                                       = CTP_BYTE_ZERO;
        stat_rd[CTP_STAT_WAVE]                        = st_q.wave;
        stat_rd[CTP_STAT_ALT_SEL]                     = st_q.alt_sel;
        stat_rd[CTP_STAT_OUT]                         = st_q.pin;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d          = st_q;
        st_d.low_irq  = 1'b0;
        st_d.high_irq = 1'b0;

        // Register writes
        if (wr_i) begin
            case (addr_i)
                CTP_ADDR_CTRL: begin
                    st_d.low_run  = wdata_i[CTP_CTRL_LOW_RUN];
                    st_d.high_run = wdata_i[CTP_CTRL_HIGH_RUN];
                    st_d.out_en   = wdata_i[CTP_CTRL_OUT_EN];
                    st_d.clk_sel  = wdata_i[CTP_CTRL_SEL_MSB:CTP_CTRL_SEL_LSB];
                    st_d.mode     = ctp_mode_e'(wdata_i[CTP_CTRL_MODE_MSB:CTP_CTRL_MODE_LSB]);
                end
                CTP_ADDR_LOW_CMP:  st_d.low_cmp  = wdata_i[CNT_W-1:0];
                CTP_ADDR_HIGH_CMP: st_d.high_cmp = wdata_i[CNT_W-1:0];
                CTP_ADDR_ALT_CMP:  st_d.alt_cmp  = wdata_i[CNT_W-1:0];
                CTP_ADDR_CAR_CTRL: begin
                    st_d.remote_sel = wdata_i[CTP_CAR_REMOTE_SEL];
                    st_d.gate_buf   = wdata_i[CTP_CAR_GATE_BUF];
                    if (!st_q.out_en) begin
                        st_d.gate_flag = wdata_i[CTP_CAR_GATE_FLAG];
                    end
                end
                default: begin
                end
            endcase
        end

        // Carrier stop drops the buffered gate value
        if (st_q.mode == CTP_MODE_CARRIER && !st_d.low_run && st_q.low_run &&
            !(wr_i && addr_i == CTP_ADDR_CAR_CTRL)) begin
            st_d.gate_buf = 1'b0;
        end

        // Counting
        if (!st_q.low_run) begin
            st_d.low_cnt  = CNT_ZERO;
            st_d.wave     = 1'b0;
            st_d.alt_sel  = 1'b0;
            if (is16 || !st_q.high_run) begin
                st_d.high_cnt = CNT_ZERO;
            end
        end else if (tick) begin
            case (st_q.mode)
                CTP_MODE_INTERVAL16,
                CTP_MODE_SQUARE16: begin
                    if (full_match) begin
                        st_d.low_cnt  = CNT_ZERO;
                        st_d.high_cnt = CNT_ZERO;
                        st_d.low_irq  = 1'b1;
                        if (st_q.mode == CTP_MODE_SQUARE16) begin
                            st_d.wave = ~st_q.wave;
                        end
                    end else begin
                        st_d.low_cnt = st_q.low_cnt + CNT_ONE;
                        if (st_q.low_cnt == CNT_FULL) begin
                            st_d.high_cnt = st_q.high_cnt + CNT_ONE;
                        end
                    end
                end
                CTP_MODE_CARRIER,
                CTP_MODE_PWM: begin
                    if (low_match) begin
                        st_d.low_cnt = CNT_ZERO;
                        st_d.low_irq = 1'b1;
                        st_d.wave    = ~st_q.wave;
                        st_d.alt_sel = ~st_q.alt_sel;
                        // High counter counts carrier periods on each rising carrier edge
                        if (st_q.mode == CTP_MODE_CARRIER && st_q.high_run && !st_q.wave) begin
                            if (st_q.high_cnt == st_q.high_cmp) begin
                                st_d.high_cnt = CNT_ZERO;
                                st_d.high_irq = 1'b1;
                            end else begin
                                st_d.high_cnt = st_q.high_cnt + CNT_ONE;
                            end
                        end
                    end else begin
                        st_d.low_cnt = st_q.low_cnt + CNT_ONE;
                    end
                end
                default: begin
                end
            endcase
        end

        // Start of output keeps the wave level low, ahead of any toggle
        if (st_d.out_en && !st_q.out_en) begin
            st_d.wave = 1'b0;
        end

        // Gate reload on the rise of the high match request
        if (st_q.high_irq) begin
            st_d.gate_flag = st_q.gate_buf;
        end

        // Pin level
        if (!st_q.out_en) begin
            st_d.pin = 1'b0;
        end else if (st_q.mode == CTP_MODE_CARRIER) begin
            if (st_q.remote_sel) begin
                st_d.pin = st_q.gate_flag;
            end else begin
                st_d.pin = st_q.wave && st_q.gate_flag;
            end
        end else if (st_q.mode == CTP_MODE_INTERVAL16) begin
            st_d.pin = 1'b0;
        end else begin
            st_d.pin = st_q.wave;
        end
        st_d.oe = st_q.out_en;

        // Read data, valid the cycle after the strobe
        st_d.rdata = CTP_BYTE_ZERO;
        if (rd_i) begin
            case (addr_i)
                CTP_ADDR_CTRL:     st_d.rdata = ctrl_rd;
                CTP_ADDR_LOW_CMP:  st_d.rdata = 8'(st_q.low_cmp);
                CTP_ADDR_HIGH_CMP: st_d.rdata = 8'(st_q.high_cmp);
                CTP_ADDR_ALT_CMP:  st_d.rdata = 8'(st_q.alt_cmp);
                CTP_ADDR_CAR_CTRL: st_d.rdata = car_rd;
                CTP_ADDR_LOW_CNT:  st_d.rdata = 8'(st_q.low_cnt);
                CTP_ADDR_HIGH_CNT: st_d.rdata = 8'(st_q.high_cnt);
                CTP_ADDR_STATUS:   st_d.rdata = stat_rd;
                default:           st_d.rdata = CTP_BYTE_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q      <= '0;
            st_q.mode <= CTP_MODE_INTERVAL16;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_o          = st_q.rdata;
    assign timer_out_pin_o  = st_q.pin;
    assign timer_out_oe_o   = st_q.oe;
    assign low_match_irq_o  = st_q.low_irq;
    assign high_match_irq_o = st_q.high_irq;

endmodule : ctp_timer
`default_nettype wire

// ### verif/ctp_load_model.sv
// Load on the timer output pin: measures level run lengths.
// Assumes a pull-down holds the line low while the block does not drive it.
`timescale 1ns/1ps
`default_nettype none
module ctp_load_model (
    input  wire logic        clk_i,
    input  wire logic        pin_i,
    input  wire logic        oe_i,
    output logic      [15:0] hi_w_o,
    output logic      [15:0] lo_w_o,
    output logic      [15:0] rises_o
);
    logic [15:0] run   = 16'h0000;
    logic [15:0] hi_q  = 16'h0000;
    logic [15:0] lo_q  = 16'h0000;
    logic [15:0] ris_q = 16'h0000;
    logic        lvl;
    logic        prev  = 1'b0;

    // Undriven line pulled low, as with the port latch at 0
    assign lvl     = oe_i ? pin_i : 1'b0;
    assign hi_w_o  = hi_q;
    assign lo_w_o  = lo_q;
    assign rises_o = ris_q;

    always @(posedge clk_i) begin
        if (lvl === prev) begin
            run = run + 16'h0001;
        end else begin
            if (prev === 1'b1) begin
                hi_q = run;
            end else begin
                lo_q = run;
            end
            if (lvl === 1'b1) begin
                ris_q = ris_q + 16'h0001;
            end
            run  = 16'h0001;
            prev = lvl;
        end
    end
endmodule : ctp_load_model
`default_nettype wire

// ### verif/ctp_timer_sva.sv
// Port checker for the cascaded timer.
// Assumes it is bound to ctp_timer and sees every register write.
`timescale 1ns/1ps
`default_nettype none
module ctp_timer_sva
    import ctp_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       timer_out_pin_o,
    input wire logic       timer_out_oe_o,
    input wire logic       low_match_irq_o,
    input wire logic       high_match_irq_o
);
    // ----------------------------------
    // Control shadow and settle counter
    // ----------------------------------
    logic [7:0] ctrl_q;
    logic [1:0] age_q;
    logic       calm;
    logic       car;
    logic       sqpwm;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= 8'h00;
            age_q  <= 2'h0;
        end else if (wr_i && addr_i == CTP_ADDR_CTRL) begin
            ctrl_q <= wdata_i;
            age_q  <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end

    assign calm  = (age_q == 2'h3);
    assign car   = (ctrl_q[7:6] == CTP_MODE_CARRIER);
    assign sqpwm = (ctrl_q[7:6] == CTP_MODE_SQUARE16) || (ctrl_q[7:6] == CTP_MODE_PWM);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_rd_unmapped;
        rd_i && addr_i[3];
    endsequence
    sequence s_rd_ctrl;
        rd_i && (addr_i == CTP_ADDR_CTRL) && calm;
    endsequence
    sequence s_stopped;
        calm && !ctrl_q[CTP_CTRL_LOW_RUN];
    endsequence

    // ----------------------------------
    // Assertions
    // ----------------------------------
    a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside read");
    a_unmapped_read: assert property (s_rd_unmapped |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (s_rd_ctrl |=> rdata_o == $past(ctrl_q))
        else $error("control readback wrong");
    a_oe_copy: assert property (calm |-> timer_out_oe_o == ctrl_q[CTP_CTRL_OUT_EN])
        else $error("output enable does not follow control");
    a_oe_start_low: assert property ($rose(timer_out_oe_o) |-> !timer_out_pin_o)
        else $error("pin high when output enabled");
    a_stop_quiet: assert property (s_stopped |-> !low_match_irq_o && !high_match_irq_o)
        else $error("match pulse while stopped");
    a_stop_pin_low: assert property (s_stopped ##0 !car |-> !timer_out_pin_o)
        else $error("pin high while stopped");
    a_no_high_irq: assert property (calm && !car |-> !high_match_irq_o)
        else $error("high match pulse outside carrier mode");
    a_pin_rise_cause: assert property ($rose(timer_out_pin_o) && calm && sqpwm |-> $past(low_match_irq_o))
        else $error("pin rose without a match");

endmodule : ctp_timer_sva
`default_nettype wire

// ### verif/ctp_timer_tb.sv
// Self-checking bench for the cascaded timer.
// Assumes ctp_timer, its checker and the pin load model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ctp_timer_tb
    import ctp_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_n_i;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        pin;
    logic        oe;
    logic        lirq;
    logic        hirq;
    logic [15:0] hi_w;
    logic [15:0] lo_w;
    logic [15:0] rises;
    logic [15:0] r0;
    int          miscompares = 0;
    int          comparisons = 0;
    int          n;
    int          div [6] = '{1, 4, 2, 4, 8, 16};

    always #10 clk_i = ~clk_i;

    ctp_timer #(.CNT_W(8)) i_ctp_timer (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .timer_out_pin_o(pin), .timer_out_oe_o(oe),
        .low_match_irq_o(lirq), .high_match_irq_o(hirq));
    ctp_load_model i_ctp_load_model (.clk_i(clk_i), .pin_i(pin), .oe_i(oe), .hi_w_o(hi_w), .lo_w_o(lo_w),
        .rises_o(rises));

    // ----------------------------------
    // Bus and check tasks
    // ----------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string name);
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd   <= 1'b0;
        #1;
        chk(name, {8'h00, e}, {8'h00, rdata});
    endtask : rd_chk

    // Bounded wait for low irq (0), high irq (1) or pin high (2)
    task automatic wait_sig(input int which, input int lim, output int cnt);
        logic s;
        cnt = 0;
        s = 1'b0;
        while (s !== 1'b1) begin
            @(posedge clk_i);
            #1;
            cnt++;
            s = (which == 0) ? lirq : (which == 1) ? hirq : pin;
            if (cnt >= lim && s !== 1'b1) begin
                miscompares++;
                $display("CHECK FAILED wait %0d expected 1 seen %b", which, s);
                report_and_stop();
            end
        end
    endtask : wait_sig

    task automatic period(input int e);
        wait_sig(0, 2000, n);
        wait_sig(0, 2000, n);
        chk("irq period", 16'(e), 16'(n));
    endtask : period

    task automatic widths(input logic [15:0] hw, input logic [15:0] lw);
        repeat (3) wait_sig(0, 2000, n);
        repeat (3) @(posedge clk_i);
        #1;
        chk("high width", hw, hi_w);
        chk("low width", lw, lo_w);
    endtask : widths

    // ----------------------------------
    // Main sequence
    // ----------------------------------
    initial begin
        rst_n_i = 1'b0;
        addr    = 4'h0;
        wdata   = 8'h00;
        wr      = 1'b0;
        rd      = 1'b0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int a = 0; a < 16; a++) rd_chk(4'(a), 8'h00, "reset value");
        wr_reg(CTP_ADDR_LOW_CMP, 8'ha5);
        rd_chk(CTP_ADDR_LOW_CMP, 8'ha5, "low compare");
        wr_reg(CTP_ADDR_LOW_CNT, 8'h3c);
        rd_chk(CTP_ADDR_LOW_CNT, 8'h00, "counter read only");
        wr_reg(4'h9, 8'hff);
        rd_chk(4'h9, 8'h00, "unmapped");
        // 16-bit interval with carry into the high counter, then at each count clock select
        wr_reg(CTP_ADDR_HIGH_CMP, 8'h01);
        wr_reg(CTP_ADDR_LOW_CMP, 8'h02);
        wr_reg(CTP_ADDR_CTRL, 8'h01);
        period(259);
        wr_reg(CTP_ADDR_CTRL, 8'h00);
        wr_reg(CTP_ADDR_HIGH_CMP, 8'h00);
        wr_reg(CTP_ADDR_LOW_CMP, 8'h03);
        for (int s = 0; s < 6; s++) begin
            wr_reg(CTP_ADDR_CTRL, {2'h0, 3'(s), 3'h3});
            period(4 * div[s]);
            wr_reg(CTP_ADDR_CTRL, 8'h00);
        end
        // 16-bit square wave
        wr_reg(CTP_ADDR_CTRL, 8'h44);
        repeat (3) @(posedge clk_i);
        #1;
        chk("pin at enable", 16'h0000, {15'h0000, pin});
        chk("oe at enable", 16'h0001, {15'h0000, oe});
        wr_reg(CTP_ADDR_LOW_CMP, 8'h04);
        wr_reg(CTP_ADDR_CTRL, 8'h45);
        widths(16'h0005, 16'h0005);
        wait_sig(2, 50, n);
        wr_reg(CTP_ADDR_CTRL, 8'h44);
        repeat (3) @(posedge clk_i);
        #1;
        chk("pin after stop", 16'h0000, {15'h0000, pin});
        // PWM
        wr_reg(CTP_ADDR_LOW_CMP, 8'h02);
        wr_reg(CTP_ADDR_ALT_CMP, 8'h05);
        wr_reg(CTP_ADDR_CTRL, 8'hc5);
        widths(16'h0006, 16'h0003);
        wr_reg(CTP_ADDR_CTRL, 8'hc4);
        repeat (3) @(posedge clk_i);
        rd_chk(CTP_ADDR_STATUS, 8'h00, "status after stop");
        // Carrier generator
        wr_reg(CTP_ADDR_CTRL, 8'h80);
        wr_reg(CTP_ADDR_HIGH_CMP, 8'h02);
        wr_reg(CTP_ADDR_LOW_CMP, 8'h01);
        wr_reg(CTP_ADDR_ALT_CMP, 8'h01);
        wr_reg(CTP_ADDR_CAR_CTRL, 8'h02);
        rd_chk(CTP_ADDR_CAR_CTRL, 8'h02, "carrier control");
        wr_reg(CTP_ADDR_CTRL, 8'h84);
        wr_reg(CTP_ADDR_CAR_CTRL, 8'h03);
        rd_chk(CTP_ADDR_CAR_CTRL, 8'h02, "gate write while enabled");
        rd_chk(CTP_ADDR_CTRL, 8'h84, "control readback");
        r0 = rises;
        wr_reg(CTP_ADDR_CTRL, 8'h87);
        wait_sig(1, 500, n);
        chk("pin gated off", r0, rises);
        repeat (2) @(posedge clk_i);
        rd_chk(CTP_ADDR_CAR_CTRL, 8'h03, "gate reload");
        widths(16'h0002, 16'h0002);
        wr_reg(CTP_ADDR_CAR_CTRL, 8'h01);
        wait_sig(1, 500, n);
        repeat (4) @(posedge clk_i);
        rd_chk(CTP_ADDR_CAR_CTRL, 8'h00, "gate cleared");
        r0 = rises;
        repeat (20) @(posedge clk_i);
        chk("pin held low", r0, rises);
        wait_sig(1, 500, n);
        wr_reg(CTP_ADDR_CAR_CTRL, 8'h02);
        wr_reg(CTP_ADDR_CTRL, 8'h80);
        rd_chk(CTP_ADDR_CAR_CTRL, 8'h00, "gate buffer after stop");
        report_and_stop();
    end
endmodule : ctp_timer_tb

bind ctp_timer ctp_timer_sva #(.CNT_W(CNT_W)) i_ctp_timer_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_out_pin_o(timer_out_pin_o),
    .timer_out_oe_o(timer_out_oe_o), .low_match_irq_o(low_match_irq_o), .high_match_irq_o(high_match_irq_o));
`default_nettype wire
